//--- rtl/lprc_core.sv
`timescale 1ns/100ps
module lprc_core #(
   parameter int TW = lprc_pkg::TIMER_W,
   parameter int NREC = lprc_pkg::FAULT_RECORDS
) (
   input  wire logic                       clock,
   input  wire logic                       sys_rst,
   input  wire logic                       quarter_tick,
   input  wire logic                       phase_a_fault_detector,
   input  wire logic                       phase_b_fault_detector,
   input  wire logic                       phase_c_fault_detector,
   input  wire logic                       zone1_three_phase_mho,
   input  wire logic                       zone2_three_phase_mho,
   input  wire logic                       zone3_three_phase_mho,
   input  wire logic                       zone1_line_line_mho,
   input  wire logic                       zone2_line_line_mho,
   input  wire logic                       zone3_line_line_mho,
   input  wire logic                       loss_of_potential,
   input  wire logic                       lop_supervision_en,
   input  wire logic                       phase_toc_pickup,
   input  wire logic                       residual_toc_pickup,
   input  wire logic                       residual_inst_oc_1,
   input  wire logic                       residual_inst_oc_2,
   input  wire logic                       residual_inst_oc_3,
   input  wire logic                       neg_seq_fwd_torque,
   input  wire logic                       neg_seq_rev_torque,
   input  wire logic                       zero_seq_v_fwd_torque,
   input  wire logic                       zero_seq_v_rev_torque,
   input  wire logic                       zero_seq_i_fwd_torque,
   input  wire logic                       zero_seq_i_rev_torque,
   input  wire logic                       neg_seq_directional_en,
   input  wire logic                       zero_seq_voltage_polarized_en,
   input  wire logic                       zero_seq_current_polarized_en,
   input  wire logic                       zone3_reverse,
   input  wire logic                       residual_toc_directional,
   input  wire logic [TW-1:0]              zone3_delay,
   input  wire logic [TW-1:0]              residual2_delay,
   input  wire logic [TW-1:0]              residual3_delay,
   input  wire logic [lprc_pkg::VOLT_W-1:0] line_voltage,
   input  wire logic [lprc_pkg::VOLT_W-1:0] dead_line_threshold,
   input  wire logic [lprc_pkg::VOLT_W-1:0] live_line_threshold,
   input  wire logic [lprc_pkg::VOLT_W-1:0] polarizing_voltage,
   input  wire logic                       breaker_closed,
   input  wire logic [TW-1:0]              breaker_close_window_timer,
   input  wire logic [31:0]                switch_onto_fault_mask,
   input  wire logic [31:0]                reclose_initiate_mask,
   input  wire logic [31:0]                reclose_cancel_mask,
   input  wire logic [31:0]                trip_mask,
   input  lprc_pkg::lprc_vmode_t           reclose_voltage_mode,
   input  wire logic                       close_voltage_check_option,
   input  wire logic                       supervision_shot_scope,
   input  wire logic [TW-1:0]              voltage_condition_timer,
   input  wire logic [TW-1:0]              open_interval_1,
   input  wire logic [TW-1:0]              open_interval_2,
   input  wire logic [TW-1:0]              open_interval_3,
   input  wire logic                       record_trigger,
   input  wire logic                       record_active,
   input  wire logic [63:0]                record_data,
   input  wire logic [3:0]                 record_index,
   output logic [31:0]                     relay_word,
   output logic [lprc_pkg::VOLT_W-1:0]     memory_voltage,
   output logic                            trip_out,
   output logic                            close_out,
   output logic [1:0]                      shot_count,
   output logic                            reclose_lockout,
   output logic                            record_capture,
   output logic [63:0]                     record_read,
   output logic [3:0]                      record_count
);
   import lprc_pkg::*;

   typedef enum {RC_IDLE, RC_VWAIT, RC_OPEN, RC_CLOSING, RC_LOCK}
      lprc_rc_state_t;

   logic fd_all, fd_any, lp_block;
   logic z1abc, z2abc, z3abc, z1p, z2p, z3p, phase_toc;
   logic dir_fwd, dir_rev, d3, res_toc;
   logic z3_timeout, z2g_timeout, z3g_timeout;
   logic volt_dead, volt_live, v_ok;
   logic sotf_armed, sotf_trip, trip_now, trip_prev;
   logic window_done, vhold_done, vct_done, open_done;
   logic [TW-1:0] open_delay;
   lprc_rc_state_t state;

   assign fd_all = phase_a_fault_detector & phase_b_fault_detector
                 & phase_c_fault_detector;
   assign fd_any = phase_a_fault_detector | phase_b_fault_detector
                 | phase_c_fault_detector;
   assign lp_block = loss_of_potential & lop_supervision_en;
   assign z1abc = zone1_three_phase_mho & fd_all & ~lp_block;
   assign z2abc = zone2_three_phase_mho & fd_all & ~lp_block;
   assign z3abc = zone3_three_phase_mho & fd_all & ~lp_block;
   assign z1p = zone1_line_line_mho & fd_any & ~lp_block;
   assign z2p = zone2_line_line_mho & fd_any & ~lp_block;
   assign z3p = zone3_line_line_mho & fd_any & ~lp_block;
   assign phase_toc = phase_toc_pickup & (z2abc | z2p);

   // Torque flags already carry the threshold; neither set gives no decision, but lost potential or no enabled element forces forward
   always_comb
   begin
      dir_fwd = (neg_seq_directional_en & neg_seq_fwd_torque)
              | (zero_seq_voltage_polarized_en & zero_seq_v_fwd_torque)
              | (zero_seq_current_polarized_en & zero_seq_i_fwd_torque);
      if (loss_of_potential || polarizing_voltage == '0)
         dir_fwd = 1'b1;
      if (!(neg_seq_directional_en | zero_seq_voltage_polarized_en
            | zero_seq_current_polarized_en))
         dir_fwd = 1'b1;
      dir_rev = ((neg_seq_directional_en & neg_seq_rev_torque)
              | (zero_seq_voltage_polarized_en & zero_seq_v_rev_torque)
              | (zero_seq_current_polarized_en & zero_seq_i_rev_torque))
              & ~dir_fwd;
   end

   assign d3 = zone3_reverse ? dir_rev : dir_fwd;
   assign res_toc = residual_toc_pickup
                  & (~residual_toc_directional | dir_fwd);

   lprc_timer #(.W(TW)) u_z3 (
      .clock(clock), .sys_rst(sys_rst), .tick(quarter_tick),
      .start(z3abc | z3p), .clear(~(z3abc | z3p)),
      .delay(zone3_delay), .done(z3_timeout));
   lprc_timer #(.W(TW)) u_g2 (
      .clock(clock), .sys_rst(sys_rst), .tick(quarter_tick),
      .start(residual_inst_oc_2 & dir_fwd), .clear(~residual_inst_oc_2),
      .delay(residual2_delay > TIMER_MAX_TICKS ? TIMER_MAX_TICKS
             : residual2_delay), .done(z2g_timeout));
   lprc_timer #(.W(TW)) u_g3 (
      .clock(clock), .sys_rst(sys_rst), .tick(quarter_tick),
      .start(residual_inst_oc_3 & d3), .clear(~residual_inst_oc_3),
      .delay(residual3_delay > TIMER_MAX_TICKS ? TIMER_MAX_TICKS
             : residual3_delay), .done(z3g_timeout));

   always_ff @(posedge clock)
   begin
      if (sys_rst)
         relay_word <= 32'h0000_0000;
      else
         relay_word <= {11'h000, res_toc, z3g_timeout, z2g_timeout,
                        residual_inst_oc_3 & d3, residual_inst_oc_2 & dir_fwd,
                        residual_inst_oc_1 & dir_fwd, dir_rev, dir_fwd,
                        z3_timeout, phase_toc, phase_toc_pickup, z1p, z2p,
                        z3p, z1abc, z2abc, z3abc, loss_of_potential,
                        breaker_closed, fd_all, fd_any};
   end

   // Four-cycle voltage memory: a delay line of quarter-cycle samples
   logic [VOLT_W-1:0] vmem [MEMORY_TICKS];
   always_ff @(posedge clock)
   begin
      if (quarter_tick)
      begin
         vmem[0] <= polarizing_voltage;
         for (int i = 1; i < MEMORY_TICKS; i++)
            vmem[i] <= vmem[i-1];
      end
   end
   always_ff @(posedge clock)
   begin
      if (sys_rst)
         memory_voltage <= '0;
      else
         memory_voltage <= vmem[MEMORY_TICKS-1];
   end

   // Switch onto fault: armed while breaker open and shortly after closing
   lprc_timer #(.W(TW)) u_win (
      .clock(clock), .sys_rst(sys_rst), .tick(quarter_tick),
      .start(breaker_closed), .clear(~breaker_closed),
      .delay(breaker_close_window_timer), .done(window_done));
   assign sotf_armed = ~window_done;
   assign sotf_trip = sotf_armed
                    & |(relay_word & switch_onto_fault_mask);
   assign trip_now = sotf_trip | |(relay_word & trip_mask);

   always_ff @(posedge clock)
   begin
      if (sys_rst)
         trip_out <= 1'b0;
      else
         trip_out <= trip_now;
   end

   assign volt_dead = line_voltage <= dead_line_threshold;
   assign volt_live = line_voltage >= live_line_threshold;
   always_comb
   begin
      case (reclose_voltage_mode)
         LPRC_VS_DEAD: v_ok = volt_dead;
         LPRC_VS_LIVE: v_ok = volt_live;
         default:      v_ok = 1'b1;
      endcase
      if (supervision_shot_scope && shot_count != 2'd0)
         v_ok = 1'b1;
   end

   lprc_timer #(.W(TW)) u_vh (
      .clock(clock), .sys_rst(sys_rst), .tick(quarter_tick),
      .start((state == RC_VWAIT) & v_ok), .clear(~v_ok | (state != RC_VWAIT)),
      .delay(VOLT_HOLD_TICKS), .done(vhold_done));
   lprc_timer #(.W(TW)) u_vct (
      .clock(clock), .sys_rst(sys_rst), .tick(quarter_tick),
      .start(state == RC_VWAIT), .clear(state != RC_VWAIT),
      .delay(voltage_condition_timer), .done(vct_done));
   always_comb
   begin
      case (shot_count)
         2'd0:    open_delay = open_interval_1;
         2'd1:    open_delay = open_interval_2;
         default: open_delay = open_interval_3;
      endcase
   end
   lprc_timer #(.W(TW)) u_oi (
      .clock(clock), .sys_rst(sys_rst), .tick(quarter_tick),
      .start(state == RC_OPEN), .clear(state != RC_OPEN),
      .delay(open_delay), .done(open_done));

   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         state <= RC_IDLE;
         shot_count <= 2'd0;
      end
      else if (|(relay_word & reclose_cancel_mask))
         state <= RC_LOCK;
      else
         case (state)
            RC_IDLE:
               if (|(relay_word & reclose_initiate_mask) && !breaker_closed)
                  state <= RC_VWAIT;
               else if (breaker_closed && !trip_now)
                  shot_count <= 2'd0;
            RC_VWAIT:
               if (vhold_done)
                  state <= RC_OPEN;
               else if (vct_done)
                  state <= RC_LOCK;
            RC_OPEN:
               if (open_done)
               begin
                  if (close_voltage_check_option || v_ok)
                     state <= RC_CLOSING;
                  else
                     state <= RC_LOCK;
               end
            RC_CLOSING:
               if (breaker_closed)
               begin
                  shot_count <= shot_count + 2'd1;
                  state <= (shot_count == 2'(RECLOSE_SHOTS - 1)) ? RC_LOCK
                         : RC_IDLE;
               end
            RC_LOCK:
               if (breaker_closed && !trip_now)
               begin
                  state <= RC_IDLE;
                  shot_count <= 2'd0;
               end
            default: state <= RC_IDLE;
         endcase
   end
   assign close_out = (state == RC_CLOSING);
   assign reclose_lockout = (state == RC_LOCK);

   // Fault records ring; trip after a finished record starts another
   logic [REC_W-1:0] records [NREC];
   logic [3:0] wr_ptr;
   always_ff @(posedge clock)
   begin
      if (sys_rst)
         trip_prev <= 1'b0;
      else
         trip_prev <= trip_now;
   end
   assign record_capture = record_trigger
                         | (trip_now & ~trip_prev & ~record_active);
   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         wr_ptr <= 4'h0;
         record_count <= 4'h0;
      end
      else if (record_capture)
      begin
         wr_ptr <= (wr_ptr == 4'(NREC - 1)) ? 4'h0 : wr_ptr + 4'h1;
         if (record_count != 4'(NREC))
            record_count <= record_count + 4'h1;
      end
   end
   always_ff @(posedge clock)
   begin
      if (record_capture)
         records[wr_ptr] <= record_data;
   end
   always_ff @(posedge clock)
   begin
      if (sys_rst)
         record_read <= '0;
      else
         record_read <= records[record_index < 4'(NREC) ? record_index : 4'h0];
   end
endmodule : lprc_core

//--- rtl/lprc_pkg.sv
package lprc_pkg;
   // Timing counted in quarter cycles of the power system
   localparam int          TIMER_W           = 14;
   localparam int          TIMER_MAX_CYCLES  = 2000;
   localparam int          TICKS_PER_CYCLE   = 4;
   localparam logic [13:0] TIMER_MAX_TICKS   =
      14'(TIMER_MAX_CYCLES * TICKS_PER_CYCLE);
   localparam logic [13:0] VOLT_HOLD_TICKS   = 14'(TICKS_PER_CYCLE);
   localparam int          MEMORY_CYCLES     = 4;
   localparam logic [4:0]  MEMORY_TICKS      =
      5'(MEMORY_CYCLES * TICKS_PER_CYCLE);
   localparam int          RECLOSE_SHOTS     = 3;
   localparam int          FAULT_RECORDS     = 12;
   localparam int          WORD_W            = 32;
   localparam int          VOLT_W            = 8;
   localparam int          REC_W             = 64;
   localparam logic [13:0] TIMER_RESET_VALUE = 14'h0000;

   typedef enum logic [1:0] {LPRC_VS_NONE, LPRC_VS_DEAD, LPRC_VS_LIVE}
      lprc_vmode_t;
endpackage : lprc_pkg

//--- rtl/lprc_timer.sv
`timescale 1ns/100ps
// Definite-time pickup timer; holds its count while start drops
module lprc_timer #(
   parameter int W = 14
) (
   input  wire logic         clock,
   input  wire logic         sys_rst,
   input  wire logic         tick,
   input  wire logic         start,
   input  wire logic         clear,
   input  wire logic [W-1:0] delay,
   output logic              done
);
   import lprc_pkg::*;
   logic [W-1:0] count;

   always_ff @(posedge clock)
   begin
      if (sys_rst || clear)
         count <= W'(0);
      else if (tick && start && count < delay)
         count <= count + W'(1);
   end

   assign done = start && (count >= delay);
endmodule : lprc_timer

//--- verif/line_protection_reclose_logic_test.sv
`timescale 1ns/100ps
module line_protection_reclose_logic_test;
   import lprc_pkg::*;
   logic clock, sys_rst, quarter_tick, manual_close, breaker_closed;
   logic phase_a_fault_detector, phase_b_fault_detector;
   logic phase_c_fault_detector, zone1_three_phase_mho;
   logic zone2_three_phase_mho, zone3_three_phase_mho;
   logic zone1_line_line_mho, zone2_line_line_mho, zone3_line_line_mho;
   logic loss_of_potential, lop_supervision_en, phase_toc_pickup;
   logic residual_toc_pickup, residual_inst_oc_1, residual_inst_oc_2;
   logic residual_inst_oc_3, neg_seq_fwd_torque, neg_seq_rev_torque;
   logic zero_seq_v_fwd_torque, zero_seq_v_rev_torque;
   logic zero_seq_i_fwd_torque, zero_seq_i_rev_torque;
   logic neg_seq_directional_en, zero_seq_voltage_polarized_en;
   logic zero_seq_current_polarized_en, zone3_reverse;
   logic residual_toc_directional, close_voltage_check_option;
   logic supervision_shot_scope, record_trigger, record_active;
   logic trip_out, close_out, reclose_lockout, record_capture, seen;
   logic [13:0] zone3_delay, residual2_delay, residual3_delay;
   logic [13:0] breaker_close_window_timer, voltage_condition_timer;
   logic [13:0] open_interval_1, open_interval_2, open_interval_3;
   logic [7:0]  line_voltage, dead_line_threshold, live_line_threshold;
   logic [7:0]  polarizing_voltage, memory_voltage;
   logic [31:0] switch_onto_fault_mask, reclose_initiate_mask;
   logic [31:0] reclose_cancel_mask, trip_mask, relay_word;
   logic [63:0] record_data, record_read;
   logic [3:0]  record_index, record_count;
   logic [1:0]  shot_count;
   logic [1:0]  tdiv = 2'h0;
   logic [2:0]  zbits;
   lprc_vmode_t reclose_voltage_mode;
   int          bad_count, compares, cycles, n;
   // Row: detectors a..c, z1abc, z1p, z2abc, toc, lop, lop_en, bits 11/9/6
   logic [11:0] rows [8] = '{12'hf01, 12'h700, 12'h282, 12'h080,
                             12'h898, 12'h892, 12'he64, 12'he20};
   assign zbits = {relay_word[11], relay_word[9], relay_word[6]};
   lprc_core uut (.*);
   lprc_breaker_model brk (.*);
   initial
   begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   // Quarter power cycle every 4 clocks keeps the reclose walks short
   always @(posedge clock)
   begin
      tdiv <= tdiv + 2'h1;
      quarter_tick <= (tdiv == 2'h3);
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         bad_count++;
         final_report();
      end
   end
   task check(input string what, input logic [31:0] got, exp);
      compares++;
      if (got !== exp)
      begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task settle;
      repeat (3) @(posedge clock);
      #1;
   endtask : settle
   task fault_trip;
      @(posedge clock);
      {phase_a_fault_detector, zone1_line_line_mho} <= 2'h3;
      for (n = 0; n < 50 && breaker_closed !== 1'b0; n++) @(posedge clock);
      check("breaker_open", breaker_closed, 1'b0);
      repeat (2) @(posedge clock);
      {phase_a_fault_detector, zone1_line_line_mho} <= 2'h0;
   endtask : fault_trip
   task final_report;
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : final_report
   initial
   begin
      sys_rst = 1'b1;
      {zone1_three_phase_mho, zone2_three_phase_mho, zone3_three_phase_mho,
       zone1_line_line_mho, zone2_line_line_mho, zone3_line_line_mho,
       phase_a_fault_detector, phase_b_fault_detector, phase_c_fault_detector,
       loss_of_potential, lop_supervision_en, phase_toc_pickup,
       residual_toc_pickup, residual_inst_oc_1, residual_inst_oc_2,
       residual_inst_oc_3, neg_seq_fwd_torque, neg_seq_rev_torque,
       zero_seq_v_fwd_torque, zero_seq_v_rev_torque, zero_seq_i_fwd_torque,
       zero_seq_i_rev_torque, neg_seq_directional_en, zone3_reverse,
       zero_seq_voltage_polarized_en, zero_seq_current_polarized_en,
       residual_toc_directional, close_voltage_check_option, manual_close,
       supervision_shot_scope, record_trigger, record_active} = '0;
      {zone3_delay, residual2_delay} = {14'h0008, 14'h0004};
      {residual3_delay, open_interval_1} = {14'h0004, 14'h0008};
      {breaker_close_window_timer, open_interval_2, open_interval_3} = '0;
      voltage_condition_timer = 14'h0028;
      {line_voltage, live_line_threshold} = 16'h0040;
      {dead_line_threshold, polarizing_voltage} = 16'h1000;
      {switch_onto_fault_mask, reclose_initiate_mask} = '0;
      {reclose_cancel_mask, trip_mask, record_data, record_index} = '0;
      reclose_voltage_mode = LPRC_VS_DEAD;
      repeat (8) @(posedge clock);
      sys_rst <= 1'b0;
      @(posedge clock);
      #1 check("reset_outs",
         {trip_out, close_out, shot_count, record_count}, 8'h00);
      foreach (rows[i])
      begin
         @(posedge clock);
         {phase_a_fault_detector, phase_b_fault_detector,
          phase_c_fault_detector, zone1_three_phase_mho, zone1_line_line_mho,
          zone2_three_phase_mho, phase_toc_pickup, loss_of_potential,
          lop_supervision_en} <= rows[i][11:3];
         settle();
         check("zone_bits", zbits, rows[i][2:0]);
      end
      @(posedge clock);
      {phase_a_fault_detector, phase_b_fault_detector, phase_c_fault_detector,
       zone2_three_phase_mho, phase_toc_pickup, neg_seq_directional_en,
       zero_seq_voltage_polarized_en, zero_seq_current_polarized_en} <= 8'h07;
      settle();
      check("fwd_lost", relay_word[13], 1'b1);
      @(posedge clock);
      polarizing_voltage <= 8'h40;
      settle();
      check("no_dir", relay_word[14:13], 2'h0);
      @(posedge clock);
      neg_seq_rev_torque <= 1'b1;
      settle();
      check("rev_dir", relay_word[14], 1'b1);
      @(posedge clock);
      neg_seq_directional_en <= 1'b0;
      settle();
      check("rev_off", relay_word[14], 1'b0);
      @(posedge clock);
      {neg_seq_rev_torque, polarizing_voltage} <= 9'h000;
      {phase_a_fault_detector, phase_b_fault_detector, phase_c_fault_detector,
       zone3_three_phase_mho, residual_inst_oc_2} <= 5'h1f;
      repeat (8) @(posedge clock);
      #1 check("tmr_early", {relay_word[18], relay_word[12]}, 2'h0);
      repeat (60) @(posedge clock);
      #1 check("tmr_done", {relay_word[18], relay_word[12]}, 2'h3);
      @(posedge clock);
      {phase_a_fault_detector, phase_b_fault_detector, phase_c_fault_detector,
       zone3_three_phase_mho, residual_inst_oc_2} <= 5'h00;
      {trip_mask, reclose_initiate_mask} <= {32'h0000_0200, 32'h0000_0200};
      fault_trip();
      for (n = 0; n < 400 && close_out !== 1'b1; n++) @(posedge clock);
      check("dead_close", close_out, 1'b1);
      check("open_wait", n >= 36, 1'b1);
      for (n = 0; n < 50 && breaker_closed !== 1'b1; n++) @(posedge clock);
      reclose_voltage_mode <= LPRC_VS_LIVE;
      fault_trip();
      seen = 1'b0;
      repeat (300)
      begin
         @(posedge clock);
         seen = seen | (close_out === 1'b1);
      end
      check("live_refused", seen, 1'b0);
      check("vct_lockout", reclose_lockout, 1'b1);
      manual_close <= 1'b1;
      repeat (8) @(posedge clock);
      manual_close <= 1'b0;
      reclose_voltage_mode <= LPRC_VS_NONE;
      {reclose_cancel_mask, lop_supervision_en} <= {32'h0000_0008, 1'b1};
      settle();
      check("lock_clear", reclose_lockout, 1'b0);
      fault_trip();
      loss_of_potential <= 1'b1;
      settle();
      check("cancel_lock", reclose_lockout, 1'b1);
      for (n = 0; n < 13; n++)
      begin
         @(posedge clock);
         record_trigger <= 1'b1;
         record_data <= 64'(n);
         @(posedge clock);
         record_trigger <= 1'b0;
      end
      record_index <= 4'h4;
      settle();
      check("record_count", record_count, 4'hc);
      // Three trip records came first, so slot 4 keeps the oldest survivor
      check("record_slot", record_read[31:0], 32'h0000_0001);
      polarizing_voltage <= 8'h5a;
      repeat (40) @(posedge clock);
      #1 check("mem_early", memory_voltage, 8'h00);
      repeat (40) @(posedge clock);
      #1 check("mem_late", memory_voltage, 8'h5a);
      @(posedge clock);
      loss_of_potential <= 1'b0;
      reclose_voltage_mode <= LPRC_VS_DEAD;
      close_voltage_check_option <= 1'b1;
      manual_close <= 1'b1;
      repeat (8) @(posedge clock);
      manual_close <= 1'b0;
      fault_trip();
      // Line goes live during the open interval; the option still closes
      repeat (20) @(posedge clock);
      line_voltage <= 8'h80;
      for (n = 0; n < 200 && close_out !== 1'b1; n++) @(posedge clock);
      check("cvc_close", close_out, 1'b1);
      final_report();
   end
endmodule : line_protection_reclose_logic_test

//--- verif/lprc_breaker_model.sv
`timescale 1ns/100ps
// Breaker mechanism: contacts move only after a command persists
module lprc_breaker_model #(
   parameter int OPEN_CYCLES  = 3,
   parameter int CLOSE_CYCLES = 5
) (
   input  wire logic clock,
   input  wire logic trip_out,
   input  wire logic close_out,
   input  wire logic manual_close,
   output logic      breaker_closed
);
   int   trip_run  = 0;
   int   close_run = 0;
   logic closed_q  = 1'b1;
   assign breaker_closed = closed_q;
   always @(posedge clock)
   begin
      trip_run  <= trip_out ? trip_run + 1 : 0;
      close_run <= (close_out || manual_close) ? close_run + 1 : 0;
      // Trip-free: a standing trip always wins over a close
      if (trip_out && trip_run >= OPEN_CYCLES - 1)
         closed_q <= 1'b0;
      else if (!trip_out && close_run >= CLOSE_CYCLES - 1)
         closed_q <= 1'b1;
   end
endmodule : lprc_breaker_model

//--- verif/lprc_checker.sv
`timescale 1ns/100ps
module lprc_checker #(
   parameter int TW   = lprc_pkg::TIMER_W,
   parameter int NREC = lprc_pkg::FAULT_RECORDS
) (
   input wire logic             clock,
   input wire logic             sys_rst,
   input wire logic             phase_a_fault_detector,
   input wire logic             phase_b_fault_detector,
   input wire logic             phase_c_fault_detector,
   input wire logic             zone1_line_line_mho,
   input wire logic             loss_of_potential,
   input wire logic             lop_supervision_en,
   input wire logic [7:0]       polarizing_voltage,
   input wire logic [7:0]       line_voltage,
   input wire logic [7:0]       dead_line_threshold,
   input wire logic             breaker_closed,
   input wire logic [31:0]      reclose_cancel_mask,
   input lprc_pkg::lprc_vmode_t reclose_voltage_mode,
   input wire logic             close_voltage_check_option,
   input wire logic             supervision_shot_scope,
   input wire logic [31:0]      relay_word,
   input wire logic             close_out,
   input wire logic             reclose_lockout,
   input wire logic [3:0]       record_count
);
   import lprc_pkg::*;
   logic lop_block;
   logic any_fd;
   assign lop_block = lop_supervision_en && loss_of_potential;
   assign any_fd = phase_a_fault_detector || phase_b_fault_detector
      || phase_c_fault_detector;
   default clocking dc @(posedge clock);
   endclocking
   default disable iff (sys_rst);
   sequence s_dead_close;
      $rose(close_out) && reclose_voltage_mode == LPRC_VS_DEAD
         && !close_voltage_check_option && !supervision_shot_scope;
   endsequence
   sequence s_cancel_hit;
      (|(relay_word & reclose_cancel_mask)) && !breaker_closed;
   endsequence
   chk_all_fd_bit: assert property (
      !$past(sys_rst) |-> relay_word[1] == $past(phase_a_fault_detector
         && phase_b_fault_detector && phase_c_fault_detector))
      else $error("all-detector bit wrong");
   chk_any_fd_bit: assert property (
      !$past(sys_rst) |-> relay_word[0] == $past(any_fd))
      else $error("any-detector bit wrong");
   chk_line_fd_gate: assert property (
      relay_word[9] |-> $past(zone1_line_line_mho && any_fd))
      else $error("zone 1 line-line set without detector");
   chk_lop_block: assert property (
      $past(lop_block) && $past(lop_block, 2) |-> relay_word[9:7] == 3'h0)
      else $error("line-line zone set during lost potential");
   chk_fwd_on_loss: assert property (
      !$past(sys_rst) && $past(polarizing_voltage == 8'h00) |-> relay_word[13])
      else $error("direction not forward with voltage lost");
   chk_dead_close: assert property (
      s_dead_close |-> $past(line_voltage <= dead_line_threshold))
      else $error("close without dead line");
   chk_cancel_lock: assert property (
      s_cancel_hit |-> ##[1:2] reclose_lockout)
      else $error("cancel did not lock out");
   chk_record_cap: assert property (
      record_count <= NREC)
      else $error("record count above limit");
endmodule : lprc_checker

bind lprc_core lprc_checker #(.TW(TW), .NREC(NREC)) chk_i (.*);
